// ==== inc/rea_regs.vh ====
// Register offsets, field positions and reset values of the result event and alarm block.
`ifndef REA_REGS_VH
`define REA_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REA_CTRL_OFF      12'h000
`define REA_STAT_OFF      12'h004
`define REA_TAU_OFF       12'h008
`define REA_NVM_OFF       12'h00C
`define REA_CH_BASE       12'h010
`define REA_CH_STRIDE     12'h010
`define REA_CH_CFG_OFF    4'h0
`define REA_CH_LOW_OFF    4'h4
`define REA_CH_HIGH_OFF   4'h8
`define REA_CH_RES_OFF    4'hC

// ----------------------------------------------------------------
// Global control fields
// ----------------------------------------------------------------
`define REA_CTRL_CYCLIC   0
`define REA_CTRL_DUAL     1

// ----------------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------------
`define REA_CFG_FUNC      0
`define REA_CFG_EOC_POL   1
`define REA_CFG_WINDOW    2
`define REA_CFG_REGION    3
`define REA_CFG_ALM_POL   4
`define REA_CFG_HYST_LSB  8
`define REA_CFG_PERS_LSB  24

// ----------------------------------------------------------------
// Reset values and store key
// ----------------------------------------------------------------
`define REA_CFG_RST       32'h0000_0000
`define REA_LOW_RST       24'h00_0000
`define REA_HIGH_RST      24'hFF_FFFF
`define REA_TAU_RST       4'h0
`define REA_NVM_KEY       32'h0000_00A5

`endif

// ==== core/rea_event_alarm.v ====
// Result-ready and alarm event logic with result filter and APB register access.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "rea_regs.vh"

module rea_event_alarm #(
  parameter DW = 24,
  parameter PW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire [1:0]    res_valid,
  input  wire [2*DW-1:0] res_data,
  output wire [1:0]    res_wr,
  output wire [2*DW-1:0] res_out,
  output wire          gpio2_out,
  output wire          gpio2_oe,
  output wire          gpio3_out,
  output wire          gpio3_oe
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  function [DW:0] sat_add;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      sat_add = {1'b0, a} + {1'b0, b};
    end
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  reg  [1:0]  ctrl_ff;
  reg  [3:0]  tau_shadow_ff;
  reg  [3:0]  tau_active_ff;
  reg  [31:0] cfg_ff [0:1];
  reg  [DW-1:0] low_ff [0:1];
  reg  [DW-1:0] high_ff [0:1];
  reg  [1:0]  eoc_seen_ff;
  reg  [1:0]  alarm_ff;

  wire        acc     = psel & penable;
  wire        wr_en   = acc & pwrite;
  wire        ch_sel  = (paddr >= `REA_CH_BASE) && (paddr < (`REA_CH_BASE + 12'h020));
  wire [11:0] ch_rel  = paddr - `REA_CH_BASE;
  wire        ch_idx  = ch_rel[4];
  wire [3:0]  ch_reg  = ch_rel[3:0];
  wire        glob_ok = (paddr == `REA_CTRL_OFF) || (paddr == `REA_STAT_OFF) ||
                        (paddr == `REA_TAU_OFF) || (paddr == `REA_NVM_OFF);

  assign pready  = 1'b1;
  assign pslverr = acc & ~(glob_ok | ch_sel);

  wire [DW-1:0] flt_res [0:1];

  always @* begin
    prdata = 32'h0000_0000;
    if (ch_sel) begin
      case (ch_reg)
        `REA_CH_CFG_OFF:  prdata = cfg_ff[ch_idx];
        `REA_CH_LOW_OFF:  prdata = {{(32-DW){1'b0}}, low_ff[ch_idx]};
        `REA_CH_HIGH_OFF: prdata = {{(32-DW){1'b0}}, high_ff[ch_idx]};
        `REA_CH_RES_OFF:  prdata = {{(32-DW){1'b0}}, flt_res[ch_idx]};
        default:          prdata = 32'h0000_0000;
      endcase
    end else begin
      case (paddr)
        `REA_CTRL_OFF: prdata = {30'h0, ctrl_ff};
        `REA_STAT_OFF: prdata = {24'h0, tau_active_ff, alarm_ff, eoc_seen_ff};
        `REA_TAU_OFF:  prdata = {28'h0, tau_shadow_ff};
        default:       prdata = 32'h0000_0000;
      endcase
    end
  end

  wire       rd_stat = acc & ~pwrite & (paddr == `REA_STAT_OFF);
  wire [31:0] ctrl_w = merge({30'h0, ctrl_ff}, pwdata, pstrb);
  wire [31:0] tau_w  = merge({28'h0, tau_shadow_ff}, pwdata, pstrb);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff       <= 2'h0;
      tau_shadow_ff <= `REA_TAU_RST;
      tau_active_ff <= `REA_TAU_RST;
    end else begin
      if (wr_en && paddr == `REA_CTRL_OFF) begin
        ctrl_ff <= ctrl_w[1:0];
      end
      if (wr_en && paddr == `REA_TAU_OFF) begin
        tau_shadow_ff <= tau_w[3:0];
      end
      // A new time constant only reaches the filter on the store command.
      if (wr_en && paddr == `REA_NVM_OFF && pwdata == `REA_NVM_KEY) begin
        tau_active_ff <= tau_shadow_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel filter, comparator and pin drive
  // ----------------------------------------------------------------
  reg [1:0] pin_ff;
  reg [1:0] eoc_ff;
  wire      cyclic = ctrl_ff[`REA_CTRL_CYCLIC];
  wire      dual   = ctrl_ff[`REA_CTRL_DUAL];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      reg  [DW+15:0] acc_ff;
      reg  [DW-1:0]  out_ff;
      reg  [PW-1:0]  pers_ff;
      wire [31:0]    cfg_w  = merge(cfg_ff[g], pwdata, pstrb);
      wire [31:0]    low_w  = merge({{(32-DW){1'b0}}, low_ff[g]}, pwdata, pstrb);
      wire [31:0]    high_w = merge({{(32-DW){1'b0}}, high_ff[g]}, pwdata, pstrb);
      wire           hit    = wr_en & ch_sel & (ch_idx == g);
      wire [DW-1:0]  din    = res_data[g*DW +: DW];
      wire [DW-1:0]  hyst   = {{(DW-16){1'b0}}, cfg_ff[g][`REA_CFG_HYST_LSB +: 16]};
      wire [PW-1:0]  pers   = cfg_ff[g][`REA_CFG_PERS_LSB +: PW];
      wire           win    = cfg_ff[g][`REA_CFG_WINDOW];
      wire           reg_in = cfg_ff[g][`REA_CFG_REGION];
      wire           flt_on = cyclic & ~dual & (tau_active_ff != 4'h0);

      // Accumulator keeps 16 fraction bits; y += (x - y) >> tau.
      wire [DW+15:0] x_ext  = {din, 16'h0000};
      wire [DW+16:0] diff   = {1'b0, x_ext} - {1'b0, acc_ff};
      wire [DW+16:0] step   = $signed(diff) >>> tau_active_ff;
      wire [DW+15:0] acc_n  = flt_on ? acc_ff + step[DW+15:0] : x_ext;
      wire [DW-1:0]  y      = acc_n[DW+15:16];

      // Limits widened by hysteresis toward the side the alarm must leave from.
      wire [DW:0]    lo_up  = sat_add(low_ff[g], hyst);
      wire [DW:0]    hi_up  = sat_add(high_ff[g], hyst);
      wire [DW:0]    lo_dn  = {1'b0, low_ff[g]} - {1'b0, hyst};
      wire [DW:0]    hi_dn  = {1'b0, high_ff[g]} - {1'b0, hyst};
      wire           act    = alarm_ff[g];
      // Single limit uses the lower limit; active state keeps the wider side.
      wire           above  = act ? ({1'b0, y} > lo_dn) : ({1'b0, y} > lo_up);
      wire           below  = act ? ({1'b0, y} < lo_up) : ({1'b0, y} < lo_dn);
      wire           out_w  = act ? (({1'b0, y} < lo_up) | ({1'b0, y} > hi_dn))
                                  : (({1'b0, y} < lo_dn) | ({1'b0, y} > hi_up));
      wire           in_w   = act ? (({1'b0, y} > lo_dn) & ({1'b0, y} < hi_up))
                                  : (({1'b0, y} > lo_up) & ({1'b0, y} < hi_dn));
      wire           cond   = win ? (reg_in ? in_w : out_w) : (reg_in ? below : above);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_ff[g]  <= `REA_CFG_RST;
          low_ff[g]  <= `REA_LOW_RST;
          high_ff[g] <= `REA_HIGH_RST;
          acc_ff     <= {(DW+16){1'b0}};
          out_ff     <= {DW{1'b0}};
          pers_ff    <= {PW{1'b0}};
          alarm_ff[g] <= 1'b0;
          eoc_ff[g]  <= 1'b0;
        end else begin
          if (hit && ch_reg == `REA_CH_CFG_OFF) begin
            cfg_ff[g] <= cfg_w;
          end
          if (hit && ch_reg == `REA_CH_LOW_OFF) begin
            low_ff[g] <= low_w[DW-1:0];
          end
          if (hit && ch_reg == `REA_CH_HIGH_OFF) begin
            high_ff[g] <= high_w[DW-1:0];
          end
          eoc_ff[g] <= res_valid[g];
          if (res_valid[g]) begin
            acc_ff <= acc_n;
            out_ff <= y;
            if (cond == alarm_ff[g]) begin
              pers_ff <= {PW{1'b0}};
            end else if (pers == {PW{1'b0}} || pers_ff == pers - {{(PW-1){1'b0}}, 1'b1}) begin
              alarm_ff[g] <= cond;
              pers_ff     <= {PW{1'b0}};
            end else begin
              pers_ff <= pers_ff + {{(PW-1){1'b0}}, 1'b1};
            end
          end
        end
      end

      assign flt_res[g]          = out_ff;
      assign res_out[g*DW +: DW] = out_ff;
      assign res_wr[g]           = eoc_ff[g];

      // Pin level: result-ready pulse or alarm level, each with its own polarity.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_ff[g] <= 1'b0;
        end else if (cfg_ff[g][`REA_CFG_FUNC]) begin
          pin_ff[g] <= alarm_ff[g] ^ ~cfg_ff[g][`REA_CFG_ALM_POL];
        end else begin
          pin_ff[g] <= eoc_ff[g] ^ ~cfg_ff[g][`REA_CFG_EOC_POL];
        end
      end
    end
  endgenerate

  // Sticky result-ready seen bits clear on status read; a new result wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoc_seen_ff <= 2'b00;
    end else begin
      eoc_seen_ff <= (rd_stat ? 2'b00 : eoc_seen_ff) | eoc_ff;
    end
  end

  assign gpio2_out = pin_ff[0];
  assign gpio3_out = pin_ff[1];
  assign gpio2_oe  = 1'b1;
  assign gpio3_oe  = 1'b1;

  // Limits ordering, lower limit ceiling and hysteresis ceiling are left to software.

endmodule // rea_event_alarm

// ==== dv/rea_event_alarm_chk.sv ====
// Checker of result strobes, pin timing and register bus answers.
`timescale 1ns/100ps
module rea_event_alarm_chk #(
  parameter DW = 24,
  parameter PW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [1:0]    res_valid,
  input wire logic [1:0]    res_wr,
  input wire logic [2*DW-1:0] res_out,
  input wire logic          gpio2_out,
  input wire logic          gpio2_oe,
  input wire logic          gpio3_out,
  input wire logic          gpio3_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pins leave their reset level on the first edges, so pin timing is judged only once this has run out.
  logic [1:0] up_ff;
  wire        acc  = psel && penable;
  wire        wacc = acc && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      up_ff <= 2'h0;
    else if (up_ff != 2'h3)
      up_ff <= up_ff + 2'h1;
  end
  a_wr_after_valid0: assert property (res_valid[0] |=> res_wr[0]) else $error("lane 0 strobe missing");
  a_wr_after_valid1: assert property (res_valid[1] |=> res_wr[1]) else $error("lane 1 strobe missing");
  a_wr_has_cause: assert property (res_wr != 2'h0 |-> (res_wr & ~$past(res_valid)) == 2'h0)
    else $error("strobe without result");
  a_out_moves_on_wr: assert property ($changed(res_out[DW-1:0]) |-> res_wr[0])
    else $error("lane 0 result moved without strobe");
  a_pin2_timed: assert property ($changed(gpio2_out) && up_ff == 2'h3 |->
    $past(res_valid[0], 2) || $past(res_valid[0], 3) || $past(wacc) || $past(wacc, 2))
    else $error("pin 2 moved without cause");
  a_pin3_timed: assert property ($changed(gpio3_out) && up_ff == 2'h3 |->
    $past(res_valid[1], 2) || $past(res_valid[1], 3) || $past(wacc) || $past(wacc, 2))
    else $error("pin 3 moved without cause");
  a_pins_driven: assert property (gpio2_oe && gpio3_oe) else $error("pin not driven");
  a_unmapped_err: assert property (acc && paddr >= 12'h030 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc |-> pready && (paddr >= 12'h030 || !pslverr)) else $error("bad answer");
  cover property (res_wr[0]);
  cover property ($rose(gpio3_out));
  cover property (acc && pslverr);
endmodule // rea_event_alarm_chk

// ==== dv/rea_res_src.sv ====
// Model of the conditioning path that delivers corrected results.
`timescale 1ns/100ps
module rea_res_src #(
  parameter DW = 24
) (
  input  wire logic       pclk,
  output logic [1:0]      res_valid,
  output logic [2*DW-1:0] res_data
);
  initial begin
    res_valid = 2'h0;
    res_data = '0;
  end
  // After the strobe the lanes are inverted, so stale data never passes for a result.
  task automatic send(input int ch, input logic [DW-1:0] v);
    @(posedge pclk);
    res_valid[ch] <= 1'b1;
    res_data[ch*DW +: DW] <= v;
    @(posedge pclk);
    res_valid <= 2'h0;
    res_data <= ~res_data;
  endtask
endmodule // rea_res_src

// ==== dv/test_result_event_and_alarm_logic.sv ====
// Self-checking bench for the result event and alarm block.
`timescale 1ns/100ps
module test_result_event_and_alarm_logic;
  localparam DW = 24;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er, g2, g2e, g3, g3e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic [1:0] res_valid, res_wr;
  logic [2*DW-1:0] res_data, res_out;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] mcfg[4] = '{32'h11, 32'h19, 32'h15, 32'h1D};
  int vin[4] = '{150, 50, 250, 150};
  int vout[4] = '{50, 150, 150, 250};
  always #12.5 pclk = ~pclk;
  rea_event_alarm #(.DW(DW), .PW(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .res_valid(res_valid), .res_data(res_data), .res_wr(res_wr), .res_out(res_out),
    .gpio2_out(g2), .gpio2_oe(g2e), .gpio3_out(g3), .gpio3_oe(g3e));
  rea_res_src #(.DW(DW)) i_src (.pclk(pclk), .res_valid(res_valid), .res_data(res_data));
  task give_verdict;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      give_verdict;
    end else begin
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  task al(input int ch, input int v, input logic e);
    i_src.send(ch, v);
    @(posedge pclk);
    #1;
    chk("alarm pin", e, ch ? g3 : g2);
  endtask
  task fx(input int ch, input int v, input int e);
    i_src.send(ch, v);
    #1;
    chk("result", e, res_out[ch*DW +: DW]);
  endtask
  task eoc(input int ch, input logic pol, input int v);
    apb(1'b1, 12'h010 + 12'(ch * 16), {30'h0, pol, 1'b0});
    fx(ch, v, v);
    chk("strobe", 1'b1, res_wr[ch]);
    @(posedge pclk);
    #1;
    chk("eoc active", pol, ch ? g3 : g2);
    @(posedge pclk);
    #1;
    chk("eoc idle", !pol, ch ? g3 : g2);
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    fails++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h010, 32'h0, "cfg reset");
    rd(12'h014, 32'h0, "lower reset");
    rd(12'h018, 32'h00FF_FFFF, "upper reset");
    rd(12'h040, 32'h0, "unmapped data");
    chk("unmapped err", 1'b1, er);
    $display("test registers done");
    apb(1'b1, 12'h014, 32'd100);
    apb(1'b1, 12'h018, 32'd200);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h010, mcfg[m]);
      al(0, vin[m], 1'b1);
      al(0, vout[m], 1'b0);
    end
    apb(1'b1, 12'h010, 32'h0000_0A11);
    al(0, 110, 1'b0);
    al(0, 111, 1'b1);
    al(0, 91, 1'b1);
    al(0, 90, 1'b0);
    apb(1'b1, 12'h010, 32'h0200_001D);
    al(0, 150, 1'b0);
    al(0, 150, 1'b1);
    al(0, 250, 1'b1);
    al(0, 150, 1'b1);
    al(0, 250, 1'b1);
    al(0, 250, 1'b0);
    apb(1'b1, 12'h024, 32'd50);
    apb(1'b1, 12'h020, 32'h1);
    al(1, 51, 1'b0);
    al(1, 50, 1'b1);
    $display("test alarm done");
    for (int c = 0; c < 4; c++)
      eoc(c / 2, c[0], 32'h1234 + c / 2);
    rd(12'h004, 32'hF, "seen sticky");
    rd(12'h004, 32'hC, "seen cleared");
    $display("test eoc done");
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    fx(0, 1000, 1000);
    apb(1'b1, 12'h00C, 32'h0000_00A5);
    rd(12'h004, 32'h1D, "tau active");
    fx(0, 3000, 2000);
    fx(1, 6661, 5661);
    rd(12'h01C, 32'd2000, "result reg");
    apb(1'b1, 12'h000, 32'h3);
    fx(0, 500, 500);
    apb(1'b1, 12'h000, 32'h0);
    fx(0, 700, 700);
    $display("test filter done");
    give_verdict;
  end
endmodule // test_result_event_and_alarm_logic
bind rea_event_alarm rea_event_alarm_chk #(.DW(DW), .PW(PW)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .res_valid(res_valid), .res_wr(res_wr), .res_out(res_out), .gpio2_out(gpio2_out),
  .gpio2_oe(gpio2_oe), .gpio3_out(gpio3_out), .gpio3_oe(gpio3_oe));
